// ### logic/chgsup_top.sv
// charger safety supervisor: safety timers, pack temperature suspend, timeout flags
// assumes charger phase and comparator levels arrive asynchronously on pins
// Summary of operation
// - a pre-charge timeout flag is raised if battery voltage stays below the low threshold for the pre-charge time.
// - a fast-charge timeout flag is raised if current has not tapered to termination within the maximum time from fast-charge start.
// - each timeout sets its own status flag to 1, one for pre-charge and one for fast-charge.
// - charging is switched off while the pack is outside its safe temperature window and all timers hold their counts.
// - charging resumes when temperature returns to range and timers continue from their frozen counts.
// - temperature sensing is ignored when termination is disabled and the sense pin is above the pack-absent level.
// - a thermistor type bit defaults to the 10k curve 2 type and 0 selects the 100k curve 1 type.
// - timers are disabled when the timer enable bit is cleared or when termination is disabled.
// - fast-charge timing slows with current reduction from load sharing, low input or thermal regulation, and termination is suppressed.
`timescale 1ns/1ps
`include "chgsup_defs.svh"
module chgsup_top #(
    parameter logic [`CHGSUP_CNT_W-1:0] PRECHG_CYCLES = `CHGSUP_CNT_W'(`CHGSUP_PRECHG_CYCLES),
    parameter logic [`CHGSUP_CNT_W-1:0] FASTCHG_CYCLES = `CHGSUP_CNT_W'(`CHGSUP_FASTCHG_CYCLES)
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire chgsup_pkg::chgsup_charger_t charger_in,
    input wire chgsup_pkg::chgsup_therm_t therm_10k_in,
    input wire chgsup_pkg::chgsup_therm_t therm_100k_in,
    input wire chgsup_pkg::chgsup_reduce_t reduce_in,
    input wire logic timer_enable_wr,
    input wire logic timer_enable_val,
    input wire logic term_disable_wr,
    input wire logic term_disable_val,
    input wire logic sensor_type_wr,
    input wire logic sensor_type_val,
    input wire logic fault_clear,
    output logic charge_enable_out,
    output chgsup_pkg::chgsup_status_t charger_status_register,
    output logic [2:0] charger_config_register
);
    localparam int SYNC_W = 5 + 3 + 3 + 3;

    // ==========================================
    // input synchronisers
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    chgsup_pkg::chgsup_charger_t chg_s;
    chgsup_pkg::chgsup_therm_t t10_s;
    chgsup_pkg::chgsup_therm_t t100_s;
    chgsup_pkg::chgsup_reduce_t red_s;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {charger_in, therm_10k_in, therm_100k_in, reduce_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign {chg_s, t10_s, t100_s, red_s} = sync2_reg;

    // ==========================================
    // configuration bits
    logic timer_en_reg;
    logic timer_en_next;
    logic term_dis_reg;
    logic term_dis_next;
    logic sensor_type_reg;
    logic sensor_type_next;

    always_comb begin
        timer_en_next = timer_enable_wr ? timer_enable_val : timer_en_reg;
        term_dis_next = term_disable_wr ? term_disable_val : term_dis_reg;
        sensor_type_next = sensor_type_wr ? sensor_type_val : sensor_type_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            timer_en_reg <= `CHGSUP_TIMER_EN_RST;
            term_dis_reg <= `CHGSUP_TERM_DIS_RST;
            sensor_type_reg <= `CHGSUP_SENSOR_TYPE_RST;
        end else begin
            timer_en_reg <= timer_en_next;
            term_dis_reg <= term_dis_next;
            sensor_type_reg <= sensor_type_next;
        end
    end

    // ==========================================
    // pack temperature
    function automatic logic temp_fault(input chgsup_pkg::chgsup_therm_t t);
        temp_fault = t.pack_too_cold | t.pack_too_hot;
    endfunction : temp_fault

    logic sel_fault;
    logic sense_ignored;
    logic suspended;

    // 1 picks the 10k curve 2 comparators, 0 the 100k curve 1 ones
    assign sel_fault = sensor_type_reg ? temp_fault(t10_s) : temp_fault(t100_s);
    // no pack fitted: pin floats high, so sensing would read as permanent cold
    assign sense_ignored = term_dis_reg && (sensor_type_reg ? t10_s.ts_above_disable : t100_s.ts_above_disable);
    assign suspended = chg_s.charge_active && sel_fault && !sense_ignored;

    // ==========================================
    // timer gating and slowdown
    logic timers_on;
    logic [1:0] reduce_cnt;
    logic [`CHGSUP_SLOW_W-1:0] slow_reg;
    logic [`CHGSUP_SLOW_W-1:0] slow_next;
    logic fast_tick;
    chgsup_pkg::chgsup_phase_t phase_reg;
    chgsup_pkg::chgsup_phase_t phase_next;

    assign timers_on = timer_en_reg && !term_dis_reg;
    assign reduce_cnt = 2'(red_s.dppm_active) + 2'(red_s.vin_low_active) + 2'(red_s.thermal_reg_active);

    // approximate proportional slowdown: one tick in 2^n cycles for n active reduction loops, but only one in 4 for n = 3
    always_comb begin
        slow_next = slow_reg + `CHGSUP_SLOW_W'(1);
        case (reduce_cnt)
            2'h0: fast_tick = 1'b1;
            2'h1: fast_tick = slow_reg[0];
            default: fast_tick = &slow_reg;
        endcase
    end

    always_comb begin
        case (phase_reg)
            chgsup_pkg::CHGSUP_PH_IDLE: phase_next = chg_s.in_precharge ? chgsup_pkg::CHGSUP_PH_PRE :
                chg_s.in_fastcharge ? chgsup_pkg::CHGSUP_PH_FAST : chgsup_pkg::CHGSUP_PH_IDLE;
            chgsup_pkg::CHGSUP_PH_PRE: phase_next = chg_s.in_fastcharge ? chgsup_pkg::CHGSUP_PH_FAST :
                chg_s.charge_active ? chgsup_pkg::CHGSUP_PH_PRE : chgsup_pkg::CHGSUP_PH_IDLE;
            chgsup_pkg::CHGSUP_PH_FAST: phase_next = !chg_s.charge_active ? chgsup_pkg::CHGSUP_PH_IDLE :
                (chg_s.ibat_below_term && reduce_cnt == 2'h0) ? chgsup_pkg::CHGSUP_PH_DONE :
                chgsup_pkg::CHGSUP_PH_FAST;
            chgsup_pkg::CHGSUP_PH_DONE: phase_next = chg_s.charge_active ? chgsup_pkg::CHGSUP_PH_DONE :
                chgsup_pkg::CHGSUP_PH_IDLE;
            default: phase_next = chgsup_pkg::CHGSUP_PH_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            slow_reg <= '0;
            phase_reg <= chgsup_pkg::CHGSUP_PH_IDLE;
        end else begin
            slow_reg <= slow_next;
            phase_reg <= phase_next;
        end
    end

    // ==========================================
    // safety timers
    logic pre_run;
    logic fast_run;
    logic pre_expired;
    logic fast_expired;

    // suspension only withholds run, so the counts freeze and later continue
    assign pre_run = timers_on && !suspended && phase_reg == chgsup_pkg::CHGSUP_PH_PRE
        && !chg_s.vbat_above_lowv;
    assign fast_run = timers_on && !suspended && fast_tick
        && phase_reg == chgsup_pkg::CHGSUP_PH_FAST;

    chgsup_timer #(
        .CNT_W(`CHGSUP_CNT_W),
        .LIMIT(PRECHG_CYCLES)
    ) u_pre_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clear(phase_reg == chgsup_pkg::CHGSUP_PH_IDLE || !timers_on),
        .run(pre_run),
        .expired(pre_expired)
    );

    // timer starts at the first fast-charge cycle since it is cleared outside that phase
    chgsup_timer #(
        .CNT_W(`CHGSUP_CNT_W),
        .LIMIT(FASTCHG_CYCLES)
    ) u_fast_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .clear(phase_reg != chgsup_pkg::CHGSUP_PH_FAST || !timers_on),
        .run(fast_run),
        .expired(fast_expired)
    );

    // ==========================================
    // status and outputs
    logic pre_flag_reg;
    logic pre_flag_next;
    logic fast_flag_reg;
    logic fast_flag_next;
    logic chg_en_reg;
    logic chg_en_next;

    always_comb begin
        // expiry beats a simultaneous clear so no fault is lost
        pre_flag_next = pre_expired | (pre_flag_reg & ~fault_clear);
        fast_flag_next = fast_expired | (fast_flag_reg & ~fault_clear);
        chg_en_next = chg_s.charge_active && !suspended && !pre_flag_next && !fast_flag_next;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pre_flag_reg <= 1'b0;
            fast_flag_reg <= 1'b0;
            chg_en_reg <= 1'b0;
        end else begin
            pre_flag_reg <= pre_flag_next;
            fast_flag_reg <= fast_flag_next;
            chg_en_reg <= chg_en_next;
        end
    end

    assign charge_enable_out = chg_en_reg;
    // one driver for the whole status word
    assign charger_status_register = {
        pre_flag_reg, fast_flag_reg, !chg_en_reg,
        (reduce_cnt == 2'h0) && !term_dis_reg
    };
    assign charger_config_register = {sensor_type_reg, term_dis_reg, timer_en_reg};
endmodule : chgsup_top

// ### logic/chgsup_defs.svh
// constants of the charger safety supervisor: timer lengths, reset values, slowdown counter width
// assumes a 200 MHz system clock; times are in seconds, counts derive from them
`ifndef CHGSUP_DEFS_SVH
`define CHGSUP_DEFS_SVH
// sized at the counter width so the products below cannot overflow 32-bit arithmetic
`define CHGSUP_CLK_HZ 43'h0000BEBC200
`define CHGSUP_PRECHG_TIME_S 43'h00000000708
`define CHGSUP_FASTCHG_TIME_S 43'h00000004650
`define CHGSUP_PRECHG_CYCLES (`CHGSUP_PRECHG_TIME_S * `CHGSUP_CLK_HZ)
`define CHGSUP_FASTCHG_CYCLES (`CHGSUP_FASTCHG_TIME_S * `CHGSUP_CLK_HZ)
`define CHGSUP_CNT_W 43
`define CHGSUP_SLOW_W 2
`define CHGSUP_SENSOR_TYPE_RST 1'b1
`define CHGSUP_TIMER_EN_RST 1'b1
`define CHGSUP_TERM_DIS_RST 1'b0
`endif

// ### logic/chgsup_pkg.sv
// types of the charger safety supervisor
// assumes chgsup_defs.svh is compiled alongside
package chgsup_pkg;
    typedef enum logic [1:0] {
        CHGSUP_PH_IDLE = 2'b00,
        CHGSUP_PH_PRE = 2'b01,
        CHGSUP_PH_FAST = 2'b10,
        CHGSUP_PH_DONE = 2'b11
    } chgsup_phase_t;

    typedef struct packed {
        logic charge_active;
        logic in_precharge;
        logic in_fastcharge;
        logic vbat_above_lowv;
        logic ibat_below_term;
    } chgsup_charger_t;

    typedef struct packed {
        logic pack_too_cold;
        logic pack_too_hot;
        logic ts_above_disable;
    } chgsup_therm_t;

    typedef struct packed {
        logic dppm_active;
        logic vin_low_active;
        logic thermal_reg_active;
    } chgsup_reduce_t;

    typedef struct packed {
        logic precharge_timeout_flag;
        logic fastcharge_timeout_flag;
        logic charge_suspended;
        logic termination_allowed;
    } chgsup_status_t;
endpackage : chgsup_pkg

// ### logic/chgsup_timer.sv
// one safety timer: counts enabled ticks up to a limit and flags expiry
// assumes the caller freezes it with run low and clears it with clear high
`timescale 1ns/1ps
module chgsup_timer #(
    parameter int CNT_W = 43,
    parameter logic [CNT_W-1:0] LIMIT = '1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clear,
    input wire logic run,
    output logic expired
);
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic expired_reg;
    logic expired_next;

    // ==========================================
    // count
    always_comb begin
        count_next = count_reg;
        expired_next = expired_reg;
        if (clear) begin
            count_next = '0;
            expired_next = 1'b0;
        end else if (run && !expired_reg) begin
            count_next = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
            expired_next = (count_next >= LIMIT);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            count_reg <= '0;
            expired_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            expired_reg <= expired_next;
        end
    end

    assign expired = expired_reg;
endmodule : chgsup_timer

// ### test/chgsup_chk.sv
// port checker of the charger safety supervisor
// assumes it is bound into chgsup_top and sees only its ports
`timescale 1ns/1ps
module chgsup_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire chgsup_pkg::chgsup_therm_t therm_10k_in,
    input wire chgsup_pkg::chgsup_reduce_t reduce_in,
    input wire logic timer_enable_wr,
    input wire logic timer_enable_val,
    input wire logic term_disable_wr,
    input wire logic term_disable_val,
    input wire logic sensor_type_wr,
    input wire logic sensor_type_val,
    input wire logic fault_clear,
    input wire logic charge_enable_out,
    input wire chgsup_pkg::chgsup_status_t charger_status_register,
    input wire logic [2:0] charger_config_register
);
    // ====================
    // properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // five samples cover the three-cycle suspend path with margin
    sequence s_hot;
        (therm_10k_in.pack_too_hot && charger_config_register == 3'h5) [*5];
    endsequence
    property p_hot;
        s_hot |-> !charge_enable_out;
    endproperty
    a_hot: assert property (p_hot) else $error("charge on with hot pack");
    property p_hold;
        $past(charger_status_register.precharge_timeout_flag) && !$past(fault_clear)
            |-> charger_status_register.precharge_timeout_flag;
    endproperty
    a_hold: assert property (p_hold) else $error("timeout flag dropped");
    property p_off;
        $rose(charger_status_register.precharge_timeout_flag) |-> ##[0:2] !charge_enable_out;
    endproperty
    a_off: assert property (p_off) else $error("charge on after timeout");
    property p_fsrc;
        $rose(charger_status_register.fastcharge_timeout_flag)
            |-> $past(charger_config_register[0], 3) && !$past(charger_config_register[1], 3);
    endproperty
    a_fsrc: assert property (p_fsrc) else $error("timeout while timers off");
    property p_wte;
        timer_enable_wr |=> charger_config_register[0] == $past(timer_enable_val);
    endproperty
    a_wte: assert property (p_wte) else $error("timer enable not stored");
    property p_wtd;
        term_disable_wr |=> charger_config_register[1] == $past(term_disable_val);
    endproperty
    a_wtd: assert property (p_wtd) else $error("termination disable not stored");
    property p_wst;
        sensor_type_wr |=> charger_config_register[2] == $past(sensor_type_val);
    endproperty
    a_wst: assert property (p_wst) else $error("sensor type not stored");
    property p_term;
        (|reduce_in) [*3] |-> !charger_status_register.termination_allowed;
    endproperty
    a_term: assert property (p_term) else $error("termination during reduction");
endmodule : chgsup_chk
bind chgsup_top chgsup_chk chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .therm_10k_in(therm_10k_in),
    .reduce_in(reduce_in), .timer_enable_wr(timer_enable_wr), .timer_enable_val(timer_enable_val),
    .term_disable_wr(term_disable_wr), .term_disable_val(term_disable_val), .sensor_type_wr(sensor_type_wr),
    .sensor_type_val(sensor_type_val), .fault_clear(fault_clear), .charge_enable_out(charge_enable_out),
    .charger_status_register(charger_status_register), .charger_config_register(charger_config_register));

// ### test/chgsup_pack_model.sv
// behavioural battery pack and charger power stage
// assumes the bench sets phase, pack and load conditions as levels
`timescale 1ns/1ps
module chgsup_pack_model (
    input wire logic [1:0] phase,
    input wire logic batt_ok,
    input wire logic hot,
    input wire logic absent,
    input wire logic ntc_100k,
    input wire logic red2,
    input wire logic red1,
    input wire logic taper,
    output chgsup_pkg::chgsup_charger_t charger_in,
    output chgsup_pkg::chgsup_therm_t therm_10k_in,
    output chgsup_pkg::chgsup_therm_t therm_100k_in,
    output chgsup_pkg::chgsup_reduce_t reduce_in
);
    // current tapers under reduction too, so termination is tempting but must be held off
    // taper alone is a genuine end of charge
    assign charger_in = {phase != 2'h0, phase == 2'h1, phase == 2'h2, batt_ok || phase == 2'h2, red2 || red1 || taper};
    // limitation: a hot pack trips only the comparators of its own curve
    // an absent pack leaves the pin high, which reads as cold on both curves
    assign therm_10k_in = {absent, hot && !ntc_100k, absent};
    assign therm_100k_in = {absent, hot && ntc_100k, absent};
    assign reduce_in = {red2, red1, red2};
endmodule : chgsup_pack_model

// ### test/test_chgsup_top.sv
// self-checking bench of the charger safety supervisor
// assumes chgsup_pack_model and chgsup_chk are compiled alongside
`timescale 1ns/1ps
module test_chgsup_top;
    localparam int PRE_N = 20;
    localparam int FAST_N = 40;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] ph = 2'h0;
    logic batt_ok = 1'b0;
    logic hot = 1'b0;
    logic absent = 1'b0;
    logic red2 = 1'b0;
    logic red1 = 1'b0;
    logic taper = 1'b0;
    logic ntc_100k = 1'b0;
    logic fault_clear = 1'b0;
    logic [2:0] wr = 3'h0;
    logic [2:0] val = 3'h0;
    logic en;
    chgsup_pkg::chgsup_charger_t chg;
    chgsup_pkg::chgsup_therm_t t10;
    chgsup_pkg::chgsup_therm_t t100;
    chgsup_pkg::chgsup_reduce_t red;
    chgsup_pkg::chgsup_status_t st;
    logic [2:0] cfg;
    int n_errors = 0;
    int check_count = 0;
    int n;
    always #2.5 sys_clk = ~sys_clk;
    chgsup_pack_model pack_u (.phase(ph), .batt_ok(batt_ok), .hot(hot), .absent(absent), .ntc_100k(ntc_100k),
        .red2(red2), .red1(red1), .taper(taper), .charger_in(chg), .therm_10k_in(t10),
        .therm_100k_in(t100), .reduce_in(red));
    chgsup_top #(.PRECHG_CYCLES(43'(PRE_N)), .FASTCHG_CYCLES(43'(FAST_N))) dut_u (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .charger_in(chg), .therm_10k_in(t10), .therm_100k_in(t100), .reduce_in(red),
        .timer_enable_wr(wr[0]), .timer_enable_val(val[0]), .term_disable_wr(wr[1]), .term_disable_val(val[1]),
        .sensor_type_wr(wr[2]), .sensor_type_val(val[2]), .fault_clear(fault_clear), .charge_enable_out(en),
        .charger_status_register(st), .charger_config_register(cfg));
    // ====================
    // shared tasks
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc
    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test
    task automatic wcfg(input int b, input logic v);
        wr[b] = 1'b1;
        val[b] = v;
        cyc(1);
        wr[b] = 1'b0;
    endtask : wcfg
    // idle phase clears the timers, the pulse clears the flags
    task automatic settle(input logic [1:0] p);
        ph = 2'h0;
        hot = 1'b0;
        red2 = 1'b0;
        red1 = 1'b0;
        taper = 1'b0;
        fault_clear = 1'b1;
        cyc(6);
        fault_clear = 1'b0;
        ph = p;
    endtask : settle
    task automatic wait_fault(input int lim);
        for (n = 0; st[3:2] === 2'h0 && n < lim; n++) begin
            cyc(1);
        end
        if (st[3:2] === 2'h0) begin
            n_errors++;
            $display("Error fault wait expected flag seen none");
            end_of_test();
        end
    endtask : wait_fault
    // ====================
    // scenarios
    task automatic t_pre();
        batt_ok = 1'b1;
        settle(2'h1);
        cyc(PRE_N + 20);
        chk("pre ok flags", {2'h0, st[3:2]}, 4'h0);
        batt_ok = 1'b0;
        wait_fault(60);
        chk("pre time", 4'(n >= PRE_N && n <= PRE_N + 6), 4'h1);
        chk("pre flags", {2'h0, st[3:2]}, 4'h2);
        cyc(3);
        chk("pre off", {3'h0, en}, 4'h0);
        $display("pre-charge timeout done");
    endtask : t_pre
    task automatic t_suspend();
        settle(2'h2);
        cyc(10);
        chk("fast on", {3'h0, en}, 4'h1);
        chk("status on", {2'h0, st[1:0]}, 4'h1);
        hot = 1'b1;
        cyc(6);
        chk("hot off", {3'h0, en}, 4'h0);
        chk("status off", {2'h0, st[1:0]}, 4'h3);
        cyc(24);
        hot = 1'b0;
        cyc(6);
        chk("resume", {3'h0, en}, 4'h1);
        wait_fault(80);
        chk("fast time", 4'(n + 46 >= FAST_N + 28 && n + 46 <= FAST_N + 40), 4'h1);
        chk("fast flags", {2'h0, st[3:2]}, 4'h1);
        $display("suspend and fast timeout done");
    endtask : t_suspend
    task automatic t_slow();
        settle(2'h2);
        red2 = 1'b1;
        cyc(10);
        chk("no termination", {3'h0, st.termination_allowed}, 4'h0);
        wait_fault(200);
        chk("slow time", 4'(n + 10 >= 4 * FAST_N - 5 && n + 10 <= 4 * FAST_N + 15), 4'h1);
        settle(2'h2);
        red1 = 1'b1;
        cyc(10);
        chk("no termination one loop", {3'h0, st.termination_allowed}, 4'h0);
        wait_fault(120);
        chk("half time", 4'(n + 10 >= 2 * FAST_N - 5 && n + 10 <= 2 * FAST_N + 15), 4'h1);
        $display("slowed timer done");
    endtask : t_slow
    task automatic t_taper();
        settle(2'h2);
        taper = 1'b1;
        cyc(FAST_N + 20);
        chk("taper flags", {2'h0, st[3:2]}, 4'h0);
        chk("taper on", {3'h0, en}, 4'h1);
        $display("termination before timeout done");
    endtask : t_taper
    task automatic t_cfg();
        wcfg(1, 1'b1);
        chk("cfg term off", {1'b0, cfg}, 4'h7);
        absent = 1'b1;
        settle(2'h2);
        hot = 1'b1;
        cyc(8);
        chk("ts ignored", {3'h0, en}, 4'h1);
        absent = 1'b0;
        cyc(6);
        chk("ts sensed", {3'h0, en}, 4'h0);
        hot = 1'b0;
        cyc(FAST_N + 20);
        chk("no timeout", {2'h0, st[3:2]}, 4'h0);
        wcfg(1, 1'b0);
        wcfg(0, 1'b0);
        chk("cfg timer off", {1'b0, cfg}, 4'h4);
        settle(2'h1);
        cyc(PRE_N + 20);
        chk("timer off", {2'h0, st[3:2]}, 4'h0);
        wcfg(0, 1'b1);
        ntc_100k = 1'b1;
        settle(2'h2);
        hot = 1'b1;
        cyc(8);
        chk("10k curve", {3'h0, en}, 4'h1);
        wcfg(2, 1'b0);
        chk("cfg 100k", {1'b0, cfg}, 4'h1);
        cyc(6);
        chk("100k curve", {3'h0, en}, 4'h0);
        $display("configuration done");
    endtask : t_cfg
    initial begin
        cyc(4);
        sys_rst = 1'b0;
        chk("reset cfg", {1'b0, cfg}, 4'h5);
        chk("reset status", {st[3:2], 1'b0, en}, 4'h0);
        t_pre();
        t_suspend();
        t_taper();
        t_slow();
        t_cfg();
        end_of_test();
    end
endmodule : test_chgsup_top
